// file: verilog/amcr_map.svh
// Address map, field positions, reset values and timing counts of the mode control bank
`ifndef AMCR_MAP_SVH
`define AMCR_MAP_SVH

// ****************************************
// Register addresses (7-bit address field)
// ****************************************
`define AMCR_ADDR_SW_RESET 7'h00
`define AMCR_ADDR_PWR_FMT 7'h01

// ****************************************
// Field positions
// ****************************************
`define AMCR_RST_REQ_BIT 7
`define AMCR_DCS_OFF_BIT 7
`define AMCR_SCRAMBLE_BIT 6
`define AMCR_SIGNED_BIT 5
`define AMCR_SLEEP_BIT 4
`define AMCR_NAP_CH2_BIT 3
`define AMCR_NAP_CH1_BIT 0

// ****************************************
// Reset values and frame layout
// ****************************************
`define AMCR_REG_RESET 8'h00
`define AMCR_FRAME_LAST 5'h0f
`define AMCR_HDR_LAST 5'h07

// ****************************************
// Timing: sleep pulse during a software reset
// ****************************************
`define AMCR_CLK_PERIOD_NS 4
`define AMCR_RST_SLEEP_NS 100
`define AMCR_RST_SLEEP_CYC ((`AMCR_RST_SLEEP_NS + `AMCR_CLK_PERIOD_NS - 1) / `AMCR_CLK_PERIOD_NS)

`endif

// file: verilog/amcr_pkg.sv
// Types shared by the mode control bank modules
`default_nettype none
package amcr_pkg;
    // Serial frame sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_shift,
        st_ignore
    } amcr_state_t;

    // Converter sample word
    typedef logic [13:0] amcr_sample_t;
endpackage : amcr_pkg
`default_nettype wire

// file: verilog/amcr_link_if.sv
// Synchronised serial port signals passed from the pin stage to the register bank
`timescale 1ns/1ns
`default_nettype none
interface amcr_link_if;
    logic cs_n;     // Chip select, synchronised level
    logic sdi;      // Serial data in, synchronised level
    logic sck_rise; // One-cycle pulse on serial clock rising edge
    logic sck_fall; // One-cycle pulse on serial clock falling edge
    modport src (output cs_n, output sdi, output sck_rise, output sck_fall);
    modport dst (input cs_n, input sdi, input sck_rise, input sck_fall);
endinterface : amcr_link_if
`default_nettype wire

// file: verilog/amcr_sync.sv
// Two-stage synchronisers and serial clock edge detection for the programming pins
`timescale 1ns/1ns
`default_nettype none
module amcr_sync (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Raw pins
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    // Synchronised side
    amcr_link_if.src lk
);
    // ****************************************
    // Synchroniser chains
    // ****************************************
    logic [2:0] sync1; // First stage, read only by sync2
    logic [2:0] sync2; // Second stage, safe to use
    logic sck_prev; // Delayed copy of the settled serial clock

    // Register the pins; chip select resets high so no frame starts in reset
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1 <= 3'h1;
            sync2 <= 3'h1;
            sck_prev <= 1'b0;
        end else begin
            sync1 <= {sdi_in, sck_in, cs_n_in};
            sync2 <= sync1;
            sck_prev <= sync2[1];
        end
    end

    // ****************************************
    // Edge pulses
    // ****************************************
    // Data and clock share the same latency, so sdi is aligned with its edge
    always_comb begin
        lk.cs_n = sync2[0];
        lk.sdi = sync2[2];
        lk.sck_rise = sync2[1] & ~sck_prev;
        lk.sck_fall = ~sync2[1] & sck_prev;
    end
endmodule : amcr_sync
`default_nettype wire

// file: verilog/amcr_regs.sv
// Serially programmed mode control bank: reset register and power/format register
// Functional notes
// - 16-bit frame: R/W, 7 address, 8 data
// - Reads return register, ignore data, no update
// - Reset register at 00h, only bit 7
// - Writing D7 one clears all mode registers
// - After reset every mode register reads 00h
// - Reset bit self-clears when command ends
// - Software reset briefly forces sleep state
// - Reset register write-only, reads return zero
// - Bit 6 enables output randomizer
// - Randomizer XORs LSB into other bits
// - Sleep/nap power down; nap keeps reference, clock
`timescale 1ns/1ns
`default_nettype none
`include "amcr_map.svh"
module amcr_regs import amcr_pkg::*; (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Serial programming pins
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    // Mode controls
    output logic duty_stabilizer_disable_out,
    output logic output_scramble_enable_out,
    output logic signed_format_select_out,
    output logic soft_reset_flag_out,
    // Power controls
    output logic sleep_out,
    output logic ref_clk_run_out,
    output logic [1:0] channel_active_out,
    // Sample formatting
    input wire amcr_sample_t sample_ch1_in,
    input wire amcr_sample_t sample_ch2_in,
    output amcr_sample_t data_ch1_out,
    output amcr_sample_t data_ch2_out
);
    // ****************************************
    // Pin stage
    // ****************************************
    amcr_link_if lk ();

    amcr_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .cs_n_in(cs_n_in),
        .sck_in(sck_in),
        .sdi_in(sdi_in),
        .lk(lk)
    );

    // ****************************************
    // Helpers
    // ****************************************
    // Read-back value; the reset register and unmapped addresses read zero
    function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] pwr);
        reg_read = (addr == `AMCR_ADDR_PWR_FMT) ? pwr : 8'h00;
    endfunction : reg_read

    // Output word formatting: sign flip then LSB scramble
    function automatic amcr_sample_t fmt(input amcr_sample_t s, input logic sgn, input logic scr);
        amcr_sample_t v;
        v = s;
        if (sgn) begin
            v[13] = ~v[13];
        end
        if (scr) begin
            v[13:1] = v[13:1] ^ {13{v[0]}};
        end
        fmt = v;
    endfunction : fmt

    // ****************************************
    // Serial sequencer and registers
    // ****************************************
    amcr_state_t state, next_state;
    logic [4:0] bit_cnt, next_bit_cnt; // Rising edges seen in this frame
    logic [15:0] shift_in, next_shift_in; // Incoming command word
    logic [7:0] rd_shift, next_rd_shift; // Read-back byte, MSB first
    logic rd_active, next_rd_active; // Read data phase in progress
    logic sdo_oe_n, next_sdo_oe_n; // Low pulls the open-drain line down
    logic [7:0] pwr_reg, next_pwr_reg; // Power and format register
    logic rst_bit, next_rst_bit; // Reset request bit, held until frame ends
    logic [7:0] sleep_cnt, next_sleep_cnt; // Sleep pulse timer
    logic sleep_q, next_sleep_q;
    logic ref_run_q, next_ref_run_q;
    logic [1:0] ch_act_q, next_ch_act_q;
    logic [15:0] word; // Word including the bit of this edge

    // Next-state logic of the serial port
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_rd_shift = rd_shift;
        next_rd_active = rd_active;
        next_sdo_oe_n = sdo_oe_n;
        next_pwr_reg = pwr_reg;
        next_rst_bit = rst_bit;
        next_sleep_cnt = (sleep_cnt != 8'h00) ? sleep_cnt - 8'h01 : sleep_cnt;
        word = {shift_in[14:0], lk.sdi};
        if (lk.cs_n) begin
            // Frame over: release the line and drop the reset bit
            next_state = st_idle;
            next_bit_cnt = 5'h00;
            next_rd_active = 1'b0;
            next_sdo_oe_n = 1'b1;
            next_rst_bit = 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    next_state = st_shift;
                end
                st_shift: begin
                    if (lk.sck_rise) begin
                        next_shift_in = word;
                        next_bit_cnt = bit_cnt + 5'h01;
                        // Header complete: fetch read data early for the first falling edge
                        if (bit_cnt == `AMCR_HDR_LAST && word[7]) begin
                            next_rd_shift = reg_read(word[6:0], pwr_reg);
                            next_rd_active = 1'b1;
                        end
                        if (bit_cnt == `AMCR_FRAME_LAST) begin
                            next_state = st_ignore;
                            // Writes only; a read leaves the bank alone
                            if (!word[15]) begin
                                if (word[14:8] == `AMCR_ADDR_SW_RESET && word[`AMCR_RST_REQ_BIT]) begin
                                    next_pwr_reg = `AMCR_REG_RESET;
                                    next_rst_bit = 1'b1;
                                    next_sleep_cnt = 8'(`AMCR_RST_SLEEP_CYC);
                                end else if (word[14:8] == `AMCR_ADDR_PWR_FMT) begin
                                    next_pwr_reg = word[7:0];
                                end
                            end
                        end
                    end else if (lk.sck_fall && rd_active) begin
                        // Open drain: drive low for a zero, release for a one
                        next_sdo_oe_n = rd_shift[7];
                        next_rd_shift = {rd_shift[6:0], 1'b0};
                    end
                end
                st_ignore: begin
                    // Edges after the sixteenth do nothing; end read on next fall
                    if (lk.sck_fall) begin
                        next_sdo_oe_n = 1'b1;
                        next_rd_active = 1'b0;
                    end
                end
                default: begin
                    next_state = st_idle;
                end
            endcase
        end
        // Power state: sleep stops everything, nap only the channel
        next_sleep_q = next_pwr_reg[`AMCR_SLEEP_BIT] | (next_sleep_cnt != 8'h00);
        next_ref_run_q = ~next_sleep_q;
        next_ch_act_q[0] = ~next_sleep_q & ~next_pwr_reg[`AMCR_NAP_CH1_BIT];
        next_ch_act_q[1] = ~next_sleep_q & ~next_pwr_reg[`AMCR_NAP_CH2_BIT];
    end

    // Register stage of the serial port
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= st_idle;
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            rd_shift <= 8'h00;
            rd_active <= 1'b0;
            sdo_oe_n <= 1'b1;
            pwr_reg <= `AMCR_REG_RESET;
            rst_bit <= 1'b0;
            sleep_cnt <= 8'h00;
            sleep_q <= 1'b0;
            ref_run_q <= 1'b1;
            ch_act_q <= 2'h3;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            rd_shift <= next_rd_shift;
            rd_active <= next_rd_active;
            sdo_oe_n <= next_sdo_oe_n;
            pwr_reg <= next_pwr_reg;
            rst_bit <= next_rst_bit;
            sleep_cnt <= next_sleep_cnt;
            sleep_q <= next_sleep_q;
            ref_run_q <= next_ref_run_q;
            ch_act_q <= next_ch_act_q;
        end
    end

    // ****************************************
    // Sample formatting
    // ****************************************
    amcr_sample_t fmt1, next_fmt1, fmt2, next_fmt2;

    always_comb begin
        next_fmt1 = fmt(sample_ch1_in, pwr_reg[`AMCR_SIGNED_BIT], pwr_reg[`AMCR_SCRAMBLE_BIT]);
        next_fmt2 = fmt(sample_ch2_in, pwr_reg[`AMCR_SIGNED_BIT], pwr_reg[`AMCR_SCRAMBLE_BIT]);
    end

    // One register stage on the data path
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fmt1 <= 14'h0000;
            fmt2 <= 14'h0000;
        end else begin
            fmt1 <= next_fmt1;
            fmt2 <= next_fmt2;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Line level is always zero; only the enable moves
    logic sdo_q;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= 1'b0;
        end
    end

    assign sdo_out = sdo_q;
    assign sdo_oe_n_out = sdo_oe_n;
    assign duty_stabilizer_disable_out = pwr_reg[`AMCR_DCS_OFF_BIT];
    assign output_scramble_enable_out = pwr_reg[`AMCR_SCRAMBLE_BIT];
    assign signed_format_select_out = pwr_reg[`AMCR_SIGNED_BIT];
    assign soft_reset_flag_out = rst_bit;
    assign sleep_out = sleep_q;
    assign ref_clk_run_out = ref_run_q;
    assign channel_active_out = ch_act_q;
    assign data_ch1_out = fmt1;
    assign data_ch2_out = fmt2;

    // ****************************************
    // Assertions
    // ****************************************
    logic last_rise;
    assign last_rise = !lk.cs_n && state == st_shift && lk.sck_rise && bit_cnt == `AMCR_FRAME_LAST;

    property p_reset_clears;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        last_rise && !word[15] && word[14:8] == 7'h00 && word[7] |=> pwr_reg == 8'h00 && rst_bit;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("soft reset did not clear bank");

    property p_reset_sleeps;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        last_rise && !word[15] && word[14:8] == 7'h00 && word[7] |=> sleep_out [*8];
    endproperty
    a_reset_sleeps: assert property (p_reset_sleeps) else $error("soft reset sleep pulse missing");

    property p_reset_selfclear;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        rst_bit && lk.cs_n |=> !rst_bit;
    endproperty
    a_reset_selfclear: assert property (p_reset_selfclear) else $error("reset bit stuck after frame");

    property p_read_no_update;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        last_rise && word[15] |=> $stable(pwr_reg);
    endproperty
    a_read_no_update: assert property (p_read_no_update) else $error("read changed register");

    property p_reset_reg_reads_zero;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !lk.cs_n && state == st_shift && lk.sck_rise && bit_cnt == 5'h07 && word[7:0] == 8'h80 |=> rd_shift == 8'h00;
    endproperty
    a_reset_reg_reads_zero: assert property (p_reset_reg_reads_zero) else $error("reset register read nonzero");

    property p_ignore_late_edges;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        state == st_ignore |=> $stable(pwr_reg) && $stable(shift_in);
    endproperty
    a_ignore_late_edges: assert property (p_ignore_late_edges) else $error("edge after sixteenth acted");

    property p_scramble;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        pwr_reg[6] && !pwr_reg[5] |=>
            data_ch1_out == {$past(sample_ch1_in[13:1]) ^ {13{$past(sample_ch1_in[0])}}, $past(sample_ch1_in[0])};
    endproperty
    a_scramble: assert property (p_scramble) else $error("randomizer output wrong");

    property p_twos;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !pwr_reg[6] && pwr_reg[5] |=> data_ch2_out == {~$past(sample_ch2_in[13]), $past(sample_ch2_in[12:0])};
    endproperty
    a_twos: assert property (p_twos) else $error("two's complement output wrong");

    property p_power;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        pwr_reg[4] |-> sleep_out && !ref_clk_run_out && channel_active_out == 2'h0;
    endproperty
    a_power: assert property (p_power) else $error("sleep did not power down");

    property p_nap;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        pwr_reg[0] && !pwr_reg[4] && sleep_cnt == 8'h00 |-> ref_clk_run_out && !channel_active_out[0];
    endproperty
    a_nap: assert property (p_nap) else $error("nap state wrong");
endmodule : amcr_regs
`default_nettype wire

// file: verif/amcr_host_model.sv
// Serial host model that frames configuration commands for the mode control bank
`timescale 1ns/1ns
`default_nettype none
module amcr_host_model (
    // Serial pins toward the bank
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out,
    // Read-back line as seen after the pull-up
    input wire logic sdo_line_in
);
    // ****************************************
    // Frame engine
    // ****************************************
    localparam int half_ns = 24; // Half of the 48 ns link clock

    // Idle: deselected, clock parked low between frames
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end

    // Send a word MSB first over n_rise rising edges; edges past 16 carry ones
    // The deselect gap comes first, so a caller sees chip select just released on return
    task automatic xfer(input logic [15:0] word, input int n_rise, output logic [7:0] rd);
        rd = 8'h00;
        #(half_ns * 2);
        cs_n_out = 1'b0;
        #(half_ns);
        for (int i = 0; i < n_rise; i++) begin
            sdi_out = (i < 16) ? word[15 - i] : 1'b1;
            #(half_ns);
            sck_out = 1'b1;
            // Read bits are taken on the rise after the bank launched them
            if (i >= 8 && i < 16) begin
                rd[15 - i] = sdo_line_in;
            end
            #(half_ns);
            sck_out = 1'b0;
        end
        #(half_ns);
        cs_n_out = 1'b1;
        // Released data line must not keep showing the last bit
        sdi_out = ~sdi_out;
    endtask : xfer
endmodule : amcr_host_model
`default_nettype wire

// file: verif/amcr_regs_tb.sv
// Self-checking bench for the serially programmed mode control bank
`timescale 1ns/1ns
`default_nettype none
module amcr_regs_tb import amcr_pkg::*;;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic sys_clk_in, nrst_in, cs_n, sck, sdi, sdo, sdo_oe_n, sdo_line;
    logic dcs_off, scramble, signed_fmt, rst_flag, sleep, ref_run;
    logic [1:0] ch_act;
    amcr_sample_t s1, s2, d1, d2;
    logic [7:0] rd;
    int err_total = 0;
    int total_checks = 0;

    // Open-drain line with its external pull-up
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

    amcr_regs amcr_regs_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sck_in(sck),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .duty_stabilizer_disable_out(dcs_off),
        .output_scramble_enable_out(scramble), .signed_format_select_out(signed_fmt),
        .soft_reset_flag_out(rst_flag), .sleep_out(sleep), .ref_clk_run_out(ref_run),
        .channel_active_out(ch_act), .sample_ch1_in(s1), .sample_ch2_in(s2),
        .data_ch1_out(d1), .data_ch2_out(d2));
    amcr_host_model amcr_host_model_i (.cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi), .sdo_line_in(sdo_line));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Full 16-edge frame; rw set means read
    task automatic cmd(input logic rw, input logic [6:0] addr, input logic [7:0] data);
        amcr_host_model_i.xfer({rw, addr, data}, 16, rd);
    endtask : cmd

    // Mode pins against a value of the power/format register
    task automatic check_mode(input logic [7:0] v);
        check("mode pins", {dcs_off, scramble, signed_fmt, sleep, ref_run, ch_act},
              {v[7], v[6], v[5], v[4], ~v[4], v[4] ? 2'b00 : {~v[3], ~v[0]}});
    endtask : check_mode

    // Reference formatting: sign flip first, then LSB folded into upper bits
    function automatic amcr_sample_t fmt(input amcr_sample_t s, input logic [7:0] m);
        amcr_sample_t x;
        x = s;
        if (m[5]) x[13] = ~x[13];
        if (m[6]) x[13:1] = x[13:1] ^ {13{x[0]}};
        return x;
    endfunction : fmt

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_soft_reset();
        check("idle sdo release", sdo_oe_n, 1'b1);
        check_mode(8'h00);
        cmd(1'b0, 7'h00, 8'h80);
        check("reset flag", rst_flag, 1'b1);
        check("reset sleep", {sleep, ref_run, ch_act}, 4'b1000);
        repeat (6) @(negedge sys_clk_in);
        check("flag released", rst_flag, 1'b0);
        repeat (30) @(negedge sys_clk_in);
        check_mode(8'h00);
        cmd(1'b0, 7'h01, 8'hff);
        check_mode(8'hff);
        cmd(1'b0, 7'h00, 8'h80);
        repeat (30) @(negedge sys_clk_in);
        check_mode(8'h00);
        cmd(1'b1, 7'h01, 8'h00);
        check("cleared read", rd, 8'h00);
        $display("soft reset test done");
    endtask : t_soft_reset

    task automatic t_fields();
        logic [7:0] pat [8] = '{8'h40, 8'h20, 8'h80, 8'h09, 8'h01, 8'h08, 8'h06, 8'h10};
        foreach (pat[i]) begin
            cmd(1'b0, 7'h01, pat[i]);
            check_mode(pat[i]);
            cmd(1'b1, 7'h01, 8'h00);
            check("field read", rd, pat[i]);
        end
        $display("field test done");
    endtask : t_fields

    task automatic t_reserved();
        cmd(1'b0, 7'h01, 8'h60);
        cmd(1'b0, 7'h00, 8'h7f);
        check("no reset on low bits", {sleep, rst_flag}, 2'b00);
        cmd(1'b1, 7'h01, 8'hff);
        check("read with data ones", rd, 8'h60);
        cmd(1'b1, 7'h01, 8'h00);
        check("read left reg", rd, 8'h60);
        cmd(1'b1, 7'h00, 8'h00);
        check("reset reg read", rd, 8'h00);
        cmd(1'b0, 7'h05, 8'hff);
        cmd(1'b1, 7'h05, 8'h00);
        check("unmapped read", rd, 8'h00);
        cmd(1'b1, 7'h01, 8'h00);
        check("unmapped write", rd, 8'h60);
        $display("reserved test done");
    endtask : t_reserved

    task automatic t_edges();
        amcr_host_model_i.xfer({1'b0, 7'h01, 8'h40}, 20, rd);
        cmd(1'b1, 7'h01, 8'h00);
        check("extra edges", rd, 8'h40);
        amcr_host_model_i.xfer({1'b0, 7'h01, 8'h20}, 12, rd);
        cmd(1'b1, 7'h01, 8'h00);
        check("short frame", rd, 8'h40);
        $display("edge count test done");
    endtask : t_edges

    task automatic t_format();
        logic [7:0] modes [4] = '{8'h00, 8'h20, 8'h40, 8'h60};
        amcr_sample_t smp [5] = '{14'h0000, 14'h0001, 14'h2000, 14'h3fff, 14'h1555};
        foreach (modes[m]) begin
            cmd(1'b0, 7'h01, modes[m]);
            foreach (smp[k]) begin
                @(negedge sys_clk_in);
                s1 = smp[k];
                s2 = ~smp[k];
                @(negedge sys_clk_in);
                check("ch1 data", d1, fmt(smp[k], modes[m]));
                check("ch2 data", d2, fmt(~smp[k], modes[m]));
            end
        end
        $display("format test done");
    endtask : t_format

    // ****************************************
    // Run control
    // ****************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    // 250 MHz system clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // Whole run needs about 40 frames of roughly 1 us
    initial begin
        #100000;
        err_total++;
        $display("watchdog expired");
        end_sim();
    end

    // Main sequence: reset held 8 cycles, sync settle, then scenarios
    initial begin
        nrst_in = 1'b0;
        s1 = 14'h0000;
        s2 = 14'h0000;
        repeat (8) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        t_soft_reset();
        t_fields();
        t_reserved();
        t_edges();
        t_format();
        end_sim();
    end
endmodule : amcr_regs_tb
`default_nettype wire
